// ### rtl/aas_map.svh
// Purpose: Register indices, field positions, reset values and timing figures.
// Assumes: Printed offsets are word indices; the byte address is four times the index.
// Notes: Definitions only.
`ifndef AAS_MAP_SVH
`define AAS_MAP_SVH
// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define AAS_IDX_RESULT 18'h0402D
`define AAS_IDX_CONTROL 18'h0402E
`define AAS_ADDR_W 18
// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define AAS_CTL_ON 15
`define AAS_CTL_GO 14
`define AAS_CTL_SLP 12
`define AAS_CTL_RATE_HI 5
`define AAS_CTL_RATE_LO 0
`define AAS_RATE_MANUAL 6'h00
`define AAS_RATE_RSVD 6'h20
`define AAS_RATE_SPLIT 6'h20
// ----------------------------------------------------------------------------
// Result fields and reset values
// ----------------------------------------------------------------------------
`define AAS_RES_SRC_HI 15
`define AAS_RES_SRC_LO 12
`define AAS_RES_DATA_HI 11
`define AAS_RES_DATA_LO 0
`define AAS_SRC_RESET 4'h0
`define AAS_DATA_RESET 12'h000
`define AAS_ZERO32 32'h00000000
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define AAS_CLK_HZ 125000000
`endif

// ### rtl/aas_pkg.sv
// Purpose: Shared types of the auxiliary converter sequencer.
// Assumes: Constants live in aas_map.svh.
// Notes: Nothing here is imported; users write aas_pkg::name.
package aas_pkg;
  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [0:0] {
    AAS_IDLE = 1'b0,
    AAS_BUSY = 1'b1
  } aas_state_type;

  // One finished conversion: input code and result code travel together.
  typedef struct packed {
    logic [3:0] source;
    logic [11:0] code;
  } aas_result_type;
endpackage

// ### rtl/aas_rate_timer.sv
// Purpose: Turns the 6-bit rate code into a periodic one-cycle tick.
// Assumes: CLK_HZ is the core clock rate; a phase accumulator avoids any divider.
// Notes: Manual and reserved codes give no tick.
`timescale 1ns/1ps
`include "aas_map.svh"
module aas_rate_timer #(
  parameter int unsigned CLK_HZ = `AAS_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [5:0] rate_code,
  output logic tick
);
  logic [31:0] sps;
  logic [31:0] acc_reg;
  logic [31:0] acc_next;
  logic [31:0] sum;
  logic tick_reg;
  logic tick_next;

  // ----------------------------------------------------------------------------
  // Rate decode and accumulator
  // ----------------------------------------------------------------------------
  // Low codes step by two per second, high codes by sixteen above the split.
  always_comb begin
    if (rate_code == `AAS_RATE_MANUAL || rate_code == `AAS_RATE_RSVD) begin
      sps = `AAS_ZERO32;
    end else if (rate_code < `AAS_RATE_SPLIT) begin
      sps = {25'h0000000, rate_code, 1'b0};
    end else begin
      sps = {22'h000000, rate_code - `AAS_RATE_SPLIT, 4'h0};
    end
    sum = acc_reg + sps;
    acc_next = `AAS_ZERO32;
    tick_next = 1'b0;
    if (run && sps != `AAS_ZERO32) begin
      if (sum >= CLK_HZ) begin
        acc_next = sum - CLK_HZ;
        tick_next = 1'b1;
      end else begin
        acc_next = sum;
      end
    end
  end

  // Registers the accumulator and the tick.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      acc_reg <= `AAS_ZERO32;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  chk_reserved_no_tick: assert property (@(posedge core_clk) disable iff (!rstn)
    rate_code == `AAS_RATE_RSVD && $stable(rate_code) |=> !tick_reg)
    else $error("Reserved rate code produced a tick.");
endmodule // aas_rate_timer

// ### rtl/aas_top.sv
// Purpose: Control and result registers of the auxiliary 12-bit converter, on APB.
// Assumes: Conversion core answers each start with one done pulse carrying data and source.
// Notes: Power state inputs are levels from the device power controller.
//
// How it works
// - Result register bits 15:12 report which input the latest result came from.
// - Result register bits 11:0 hold the unsigned 12-bit conversion code.
// - Control bit 15 powers the converter, resets low, clears in OFF state.
// - With nonzero rate, periodic conversions run only while bit 14 is set.
// - With rate zero, writing one to bit 14 requests one conversion.
// - In manual mode bit 14 clears itself when the conversion finishes.
// - Bit 12 low stops the converter in SLEEP; high follows bit 15.
// - Rate code: 0 manual, 1-31 twice code, 33-63 sixteen times excess.
`timescale 1ns/1ps
`include "aas_map.svh"
module aas_top #(
  parameter int unsigned CLK_HZ = `AAS_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`AAS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwr_state_off,
  input wire logic pwr_state_sleep,
  output logic adc_power,
  output logic conv_start,
  input wire logic conv_done,
  input wire aas_pkg::aas_result_type conv_result
);
  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic [`AAS_ADDR_W-1:0] res_addr;
  logic [`AAS_ADDR_W-1:0] ctl_addr;
  logic acc_phase;
  logic hit_res;
  logic hit_ctl;
  logic wr_ctl;
  logic manual;
  logic active;
  logic tick;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic on_reg, on_next;
  logic go_reg, go_next;
  logic slp_reg, slp_next;
  logic [5:0] rate_reg, rate_next;
  aas_pkg::aas_result_type result_reg, result_next;
  aas_pkg::aas_state_type state_reg, state_next;
  logic start_reg, start_next;
  logic power_reg, power_next;

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  // Byte addresses are four times the register indices.
  assign res_addr = `AAS_ADDR_W'(`AAS_IDX_RESULT << 2);
  assign ctl_addr = `AAS_ADDR_W'(`AAS_IDX_CONTROL << 2);
  assign acc_phase = psel && penable;
  assign hit_res = paddr == res_addr;
  assign hit_ctl = paddr == ctl_addr;
  assign wr_ctl = acc_phase && pready_reg && pwrite && hit_ctl;
  assign manual = rate_reg == `AAS_RATE_MANUAL;
  // The converter runs when on, unless the device sleeps without permission.
  assign active = on_reg && (!pwr_state_sleep || slp_reg);

  // ----------------------------------------------------------------------------
  // Periodic tick source
  // ----------------------------------------------------------------------------
  aas_rate_timer #(
    .CLK_HZ(CLK_HZ)
  ) u_aas_rate_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(active && go_reg && !manual),
    .rate_code(rate_reg),
    .tick(tick)
  );

  // ----------------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------------
  // Each access waits one cycle; read data is captured in the first access cycle.
  always_comb begin
    pready_next = acc_phase && !pready_reg;
    pslverr_next = acc_phase && !pready_reg && !hit_res && !hit_ctl;
    prdata_next = prdata_reg;
    if (acc_phase && !pready_reg) begin
      prdata_next = `AAS_ZERO32;
      if (!pwrite && hit_res) begin
        prdata_next[`AAS_RES_SRC_HI:`AAS_RES_DATA_LO] = result_reg;
      end else if (!pwrite && hit_ctl) begin
        prdata_next[`AAS_CTL_ON] = on_reg;
        prdata_next[`AAS_CTL_GO] = go_reg;
        prdata_next[`AAS_CTL_SLP] = slp_reg;
        prdata_next[`AAS_CTL_RATE_HI:`AAS_CTL_RATE_LO] = rate_reg;
      end
    end
  end

  // Registers the bus answer.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= `AAS_ZERO32;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Control register and sequencer
  // ----------------------------------------------------------------------------
  // Software writes land first; a completion in manual mode clears the go bit unless a new
  // write of one arrives in the same cycle, so the new request is kept.
  always_comb begin
    on_next = on_reg;
    go_next = go_reg;
    slp_next = slp_reg;
    rate_next = rate_reg;
    result_next = result_reg;
    state_next = state_reg;
    start_next = 1'b0;
    if (wr_ctl) begin
      on_next = pwdata[`AAS_CTL_ON];
      go_next = pwdata[`AAS_CTL_GO];
      slp_next = pwdata[`AAS_CTL_SLP];
      rate_next = pwdata[`AAS_CTL_RATE_HI:`AAS_CTL_RATE_LO];
    end
    unique case (state_reg)
      aas_pkg::AAS_IDLE: begin
        if (active && go_reg && (manual ? 1'b1 : tick)) begin
          start_next = 1'b1;
          state_next = aas_pkg::AAS_BUSY;
        end
      end
      aas_pkg::AAS_BUSY: begin
        if (conv_done) begin
          result_next = conv_result;
          state_next = aas_pkg::AAS_IDLE;
          if (manual && !(wr_ctl && pwdata[`AAS_CTL_GO])) begin
            go_next = 1'b0;
          end
        end
      end
    endcase
    if (pwr_state_off) begin
      on_next = 1'b0;
    end
    power_next = on_next && (!pwr_state_sleep || slp_next);
  end

  // Registers control state and outputs.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      on_reg <= 1'b0;
      go_reg <= 1'b0;
      slp_reg <= 1'b0;
      rate_reg <= `AAS_RATE_MANUAL;
      result_reg <= {`AAS_SRC_RESET, `AAS_DATA_RESET};
      state_reg <= aas_pkg::AAS_IDLE;
      start_reg <= 1'b0;
      power_reg <= 1'b0;
    end else begin
      on_reg <= on_next;
      go_reg <= go_next;
      slp_reg <= slp_next;
      rate_reg <= rate_next;
      result_reg <= result_next;
      state_reg <= state_next;
      start_reg <= start_next;
      power_reg <= power_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign conv_start = start_reg;
  assign adc_power = power_reg;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_finish;
    state_reg == aas_pkg::AAS_BUSY && conv_done;
  endsequence

  sequence s_manual_ready;
    state_reg == aas_pkg::AAS_IDLE && manual && go_reg && active;
  endsequence

  chk_source_pairing: assert property (s_finish |=>
    result_reg.source == $past(conv_result.source) && result_reg.code == $past(conv_result.code))
    else $error("Result and source did not update together.");
  chk_data_field: assert property (result_reg.code == $past(result_reg.code) ||
    $past(state_reg == aas_pkg::AAS_BUSY && conv_done))
    else $error("Result code changed without a finished conversion.");
  chk_off_clears: assert property (pwr_state_off |=> !on_reg && !adc_power)
    else $error("Enable survived the OFF state.");
  chk_periodic_go: assert property (conv_start && !$past(manual) |-> $past(go_reg) && $past(tick))
    else $error("Periodic start without go bit and tick.");
  chk_manual_start: assert property (s_manual_ready |=> conv_start ##1 !conv_start)
    else $error("Manual request did not start one conversion.");
  chk_manual_clear: assert property (s_finish ##0 (manual && !wr_ctl) |=> !go_reg)
    else $error("Go bit not cleared after manual conversion.");
  chk_sleep_gate: assert property (pwr_state_sleep && !slp_reg && !wr_ctl |=> !adc_power)
    else $error("Converter powered in sleep without permission.");
  chk_bus_answer: assert property (acc_phase && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("Bus answer not one cycle after access start.");
endmodule // aas_top

// ### verification/aas_core_model.sv
// Purpose: Behavioural conversion core that answers each start with one result.
// Assumes: Latency LAT+1 cycles from the start pulse to the done pulse.
// Notes: Outside the done pulse the result bus toggles, so stale data is never held.
`timescale 1ns/1ps
module aas_core_model #(
  parameter int LAT = 5
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic conv_start,
  input wire logic [3:0] src,
  input wire logic [11:0] code,
  output logic conv_done,
  output aas_pkg::aas_result_type conv_result,
  output int starts
);
  int cnt;
  // Counts starts, waits the latency, then presents source and code with done.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt <= 0;
      starts <= 0;
      conv_done <= 1'b0;
      conv_result <= '0;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start) begin
        starts <= starts + 1;
        cnt <= LAT;
      end else if (cnt == 1) begin
        conv_done <= 1'b1;
        conv_result <= {src, code};
        cnt <= 0;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // aas_core_model

// ### verification/aas_top_tb_top.sv
// Purpose: Self-checking bench of the converter sequencer over APB.
// Assumes: CLK_HZ of 1000 so that rate 1 ticks every 500 cycles.
// Notes: Each scenario is its own task and judges its own results.
`timescale 1ns/1ps
module aas_top_tb_top;
  localparam logic [17:0] A_RES = 18'h100B4;
  localparam logic [17:0] A_CTL = 18'h100B8;
  localparam logic [17:0] A_BAD = 18'h100BC;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pwr_state_off = 1'b0;
  logic pwr_state_sleep = 1'b0;
  logic adc_power;
  logic conv_start;
  logic conv_done;
  aas_pkg::aas_result_type conv_result;
  logic [3:0] m_src = 4'h0;
  logic [11:0] m_code = 12'h000;
  int starts;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] r;
  logic e;

  // Design under test and the conversion core beside it.
  aas_top #(.CLK_HZ(1000)) u_aas_top (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwr_state_off(pwr_state_off),
    .pwr_state_sleep(pwr_state_sleep), .adc_power(adc_power), .conv_start(conv_start),
    .conv_done(conv_done), .conv_result(conv_result));
  aas_core_model u_aas_core_model (.core_clk(core_clk), .rstn(rstn), .conv_start(conv_start),
    .src(m_src), .code(m_code), .conv_done(conv_done), .conv_result(conv_result),
    .starts(starts));

  // Clock of 8 ns period.
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high.
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hung access.
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset values, reserved bits and an unmapped address.
  task automatic t_regs();
    apb(0, A_RES, 0);
    chk(r, 32'h0);
    apb(0, A_CTL, 0);
    chk(r, 32'h0);
    apb(0, A_BAD, 0);
    chk({r[30:0], e}, 32'h1);
    apb(1, A_CTL, 32'hFFFFFFFF);
    apb(0, A_CTL, 0);
    chk(r, 32'h0000D03F);
    apb(1, A_CTL, 32'h0);
    // Lets a conversion started by the fast rate finish before manual tests.
    repeat (16) @(posedge core_clk);
  endtask

  // Manual conversion: go self-clears and source and code arrive together.
  task automatic t_manual(input logic [3:0] s, input logic [11:0] c);
    int n;
    int s0;
    s0 = starts;
    m_src <= s;
    m_code <= c;
    apb(1, A_CTL, 32'h0000C000);
    n = 0;
    do begin
      apb(0, A_CTL, 0);
      n++;
    end while (r[14] !== 1'b0 && n < 10);
    chk(r, 32'h00008000);
    apb(0, A_RES, 0);
    chk(r, {16'h0, s, c});
    chk(starts - s0, 32'h1);
  endtask

  // Periodic mode: starts counted over a span must fall in the expected range.
  task automatic t_rate(input logic [31:0] ctl, input int span, input int lo, input int hi);
    int s0;
    apb(1, A_CTL, ctl);
    // Lets a start launched by a tick of the previous rate land before counting.
    repeat (4) @(posedge core_clk);
    s0 = starts;
    repeat (span) @(posedge core_clk);
    chk({31'h0, (starts - s0 >= lo) && (starts - s0 <= hi)}, 32'h1);
    apb(0, A_CTL, 0);
    chk(r, ctl);
  endtask

  // Converter power under SLEEP and clearing of the enable in OFF.
  task automatic t_power();
    apb(1, A_CTL, 32'h00008000);
    repeat (3) @(posedge core_clk);
    chk({31'h0, adc_power}, 32'h1);
    pwr_state_sleep <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({31'h0, adc_power}, 32'h0);
    apb(1, A_CTL, 32'h00009000);
    repeat (3) @(posedge core_clk);
    chk({31'h0, adc_power}, 32'h1);
    pwr_state_sleep <= 1'b0;
    pwr_state_off <= 1'b1;
    repeat (3) @(posedge core_clk);
    pwr_state_off <= 1'b0;
    apb(0, A_CTL, 0);
    chk(r, 32'h00001000);
    repeat (3) @(posedge core_clk);
    chk({31'h0, adc_power}, 32'h0);
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_manual(4'h1, 12'hFFF);
    t_manual(4'h2, 12'h001);
    t_manual(4'h3, 12'hA5A);
    t_manual(4'h5, 12'h1F2);
    t_manual(4'h7, 12'h800);
    t_rate(32'h00008001, 1100, 0, 0);
    t_rate(32'h0000C001, 1100, 2, 3);
    t_rate(32'h0000C021, 1000, 15, 17);
    t_rate(32'h0000C020, 1100, 0, 0);
    t_power();
    results();
  end

  // Watchdog against a hang.
  initial begin
    #150000;
    fails++;
    results();
  end
endmodule // aas_top_tb_top
